// [rtl/converter_control.v]
// Purpose: Second converter control register with power, trigger and interrupt logic
// Assumes: AXI4-Lite slave, one write and one read outstanding at a time
// Notes: Conversion engine is outside; this block steers it through pulses and levels
`timescale 1ns/10ps
`include "convctl_defines.vh"
module converter_control #(
    parameter RECOVERY_CYCLES = (`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter CHANNELS = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Conversion engine
    input wire sequence_complete_flag,
    input wire [CHANNELS-1:0] conversion_done,
    input wire wait_mode,
    output reg sequence_abort_q,
    output reg conversion_halt_q,
    output reg resume_discard_q,
    output reg analog_power_q,
    output reg converter_ready_q,
    output reg [CHANNELS-1:0] conversion_complete_flag_q,
    output reg [CHANNELS-1:0] clear_done_q,
    // External trigger
    input wire trigger_pin,
    output reg trigger_start_q,
    output reg trigger_mode_q,
    // Interrupt
    output reg irq_q
);

reg [7:0] ctl_q; // Writable control bits, bit 0 unused
reg [2:0] irq_status_q; // Sticky event bits
reg [2:0] irq_mask_q; // Event enables
reg [CHANNELS-1:0] flag_armed_q; // Status read seen per channel
reg aw_held_q; // Write address captured
reg w_held_q; // Write data captured
reg [7:0] awaddr_q; // Captured write address
reg [31:0] wdata_q; // Captured write data
reg [3:0] wstrb_q; // Captured byte enables
reg wait_halt_q; // Halt in force from wait
reg seq_prev_q; // Previous sequence flag for edge events
reg ready_prev_q; // Previous ready for edge events
wire trig_hit; // Trigger sensitivity met
wire pwr_on; // Analog powered
wire pwr_ready; // Recovery elapsed
wire wr_fire; // Write executes this cycle
wire rd_fire; // Read executes this cycle
wire [7:0] rd_word; // Read byte address selector
wire [2:0] irq_events; // Event pulses
wire [2:0] irq_w1c; // Software clear bits
wire [7:0] ctl_view; // Control value as read

// Result register decode, used for both reads and writes
function is_result;
    input [7:0] addr;
    begin
        is_result = (addr >= `ADDR_RESULT_BASE) && (addr <= `ADDR_RESULT_LAST);
    end
endfunction

// One-hot channel for a result address
function [CHANNELS-1:0] result_onehot;
    input [7:0] addr;
    reg [7:0] offs;
    begin
        offs = addr - `ADDR_RESULT_BASE;
        result_onehot = is_result(addr) ? ({{(CHANNELS-1){1'b0}}, 1'b1} << offs[4:2])
                                        : {CHANNELS{1'b0}};
    end
endfunction

trigger_detect u_trigger (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ctl_q[`BIT_TRIG_EN]),
    .level_select(ctl_q[`BIT_TRIG_LEVEL]),
    .polarity(ctl_q[`BIT_TRIG_POL]),
    .trigger_pin(trigger_pin),
    .trigger_hit_q(trig_hit)
);

power_sequencer #(
    .RECOVERY_CYCLES(RECOVERY_CYCLES)
) u_power (
    .aclk(aclk),
    .aresetn(aresetn),
    .power_request(ctl_q[`BIT_POWER_ON] & ~wait_halt_q),
    .analog_on_q(pwr_on),
    .ready_q(pwr_ready)
);

assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
assign rd_fire = s_axi_arvalid & s_axi_arready;
assign rd_word = s_axi_araddr;
// Bit 0 mirrors the sequence flag only while enabled
assign ctl_view = {ctl_q[7:1], ctl_q[`BIT_SEQ_IRQ_EN] & sequence_complete_flag};
assign irq_events = {pwr_ready & ~ready_prev_q, trig_hit, sequence_complete_flag & ~seq_prev_q};
assign irq_w1c = (wr_fire && awaddr_q == `ADDR_IRQ_STATUS && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;

// Write address and data capture, either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h00000000;
        wstrb_q <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
    end else begin
        s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end
end

// Write execution and response; control register is always writable
always @(posedge aclk) begin
    if (!aresetn) begin
        ctl_q <= `CTL_TWO_RESET;
        irq_mask_q <= 3'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        sequence_abort_q <= 1'b0;
    end else begin
        sequence_abort_q <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            if (awaddr_q == `ADDR_CTL_TWO) begin
                if (wstrb_q[0]) begin
                    ctl_q <= wdata_q[7:0] & `WRITABLE_MASK;
                end
                sequence_abort_q <= 1'b1;
            end else if (awaddr_q == `ADDR_IRQ_MASK) begin
                if (wstrb_q[0]) begin
                    irq_mask_q <= wdata_q[2:0];
                end
            end else if (awaddr_q == `ADDR_IRQ_STATUS || is_result(awaddr_q)) begin
                s_axi_bresp <= `RESP_OKAY;
            end else if (awaddr_q != `ADDR_FLAG_STATUS) begin
                s_axi_bresp <= `RESP_SLVERR; // Unmapped address
            end
        end
    end
end

// Read channel, one-cycle accept then data
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
        if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (rd_word == `ADDR_CTL_TWO) begin
                s_axi_rdata <= {24'h000000, ctl_view};
            end else if (rd_word == `ADDR_IRQ_STATUS) begin
                s_axi_rdata <= {29'h00000000, irq_status_q};
            end else if (rd_word == `ADDR_IRQ_MASK) begin
                s_axi_rdata <= {29'h00000000, irq_mask_q};
            end else if (rd_word == `ADDR_FLAG_STATUS) begin
                s_axi_rdata <= {{(32-CHANNELS){1'b0}}, conversion_complete_flag_q};
            end else if (!is_result(rd_word)) begin
                s_axi_rresp <= `RESP_SLVERR; // Unmapped address
            end
        end
    end
end

// Conversion-complete flags: set wins over clear
always @(posedge aclk) begin : flag_block
    reg [CHANNELS-1:0] clr;
    clr = {CHANNELS{1'b0}};
    if (!aresetn) begin
        conversion_complete_flag_q <= {CHANNELS{1'b0}};
        flag_armed_q <= {CHANNELS{1'b0}};
        clear_done_q <= {CHANNELS{1'b0}};
    end else begin
        if (ctl_q[`BIT_FAST_CLEAR]) begin
            // Any result access clears its flag
            if (rd_fire) begin
                clr = clr | result_onehot(rd_word);
            end
            if (wr_fire) begin
                clr = clr | result_onehot(awaddr_q);
            end
        end else if (rd_fire) begin
            // Status read arms, matching result read clears
            clr = result_onehot(rd_word) & flag_armed_q;
        end
        if (rd_fire && rd_word == `ADDR_FLAG_STATUS) begin
            flag_armed_q <= conversion_complete_flag_q;
        end else begin
            flag_armed_q <= flag_armed_q & ~clr;
        end
        conversion_complete_flag_q <= (conversion_complete_flag_q & ~clr) | conversion_done;
        clear_done_q <= clr;
    end
end

// Wait-mode halt, resume marker and drive outputs
always @(posedge aclk) begin
    if (!aresetn) begin
        wait_halt_q <= 1'b0;
        conversion_halt_q <= 1'b0;
        resume_discard_q <= 1'b0;
        analog_power_q <= 1'b0;
        converter_ready_q <= 1'b0;
        trigger_start_q <= 1'b0;
        trigger_mode_q <= 1'b0;
    end else begin
        wait_halt_q <= wait_mode & ctl_q[`BIT_WAIT_PDOWN];
        conversion_halt_q <= (wait_mode & ctl_q[`BIT_WAIT_PDOWN]) | ~ctl_q[`BIT_POWER_ON];
        // One-cycle marker when the halted conversion resumes
        resume_discard_q <= wait_halt_q & ~(wait_mode & ctl_q[`BIT_WAIT_PDOWN]);
        analog_power_q <= pwr_on;
        converter_ready_q <= pwr_ready;
        trigger_start_q <= trig_hit & pwr_ready;
        trigger_mode_q <= ctl_q[`BIT_TRIG_EN];
    end
end

// Sticky events, write-one-to-clear with set winning, and interrupt output
always @(posedge aclk) begin
    if (!aresetn) begin
        irq_status_q <= 3'h0;
        seq_prev_q <= 1'b0;
        ready_prev_q <= 1'b0;
        irq_q <= 1'b0;
    end else begin
        seq_prev_q <= sequence_complete_flag;
        ready_prev_q <= pwr_ready;
        irq_status_q <= (irq_status_q & ~irq_w1c) | irq_events;
        // Sequence flag through the enable bit, all three sticky events, sequence edge included, through the mask
        irq_q <= (ctl_q[`BIT_SEQ_IRQ_EN] & sequence_complete_flag)
               | (|(irq_status_q & irq_mask_q));
    end
end

endmodule

// [include/convctl_defines.vh]
// Purpose: Constants for the converter power, trigger and interrupt control block
// Assumes: AXI4-Lite register bus, 32-bit data, one word per register
// Notes: Byte address of an indexed register is four times its index
`ifndef CONVCTL_DEFINES_VH
`define CONVCTL_DEFINES_VH

// Register indices and byte addresses
`define IDX_CTL_TWO 8'h02
`define ADDR_CTL_TWO 8'h08
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_IRQ_MASK 8'h24
`define ADDR_FLAG_STATUS 8'h28
`define ADDR_RESULT_BASE 8'h40
`define ADDR_RESULT_LAST 8'h5C

// Control register field positions
`define BIT_POWER_ON 7
`define BIT_FAST_CLEAR 6
`define BIT_WAIT_PDOWN 5
`define BIT_TRIG_LEVEL 4
`define BIT_TRIG_POL 3
`define BIT_TRIG_EN 2
`define BIT_SEQ_IRQ_EN 1
`define BIT_SEQ_IRQ_FLAG 0

// Reset value and writable bits
`define CTL_TWO_RESET 8'h00
`define WRITABLE_MASK 8'hFE

// Recovery time after power-up
`define RECOVERY_NS 20000
`define CLK_PERIOD_NS 100

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Interrupt status bits
`define IRQ_SEQ_DONE 0
`define IRQ_TRIGGER 1
`define IRQ_READY 2

`endif

// [rtl/trigger_detect.v]
// Purpose: Synchronise the external trigger and apply the selected sensitivity
// Assumes: Trigger pin is asynchronous to aclk
// Notes: Edge modes give a one-cycle pulse, level modes a level
`timescale 1ns/10ps
module trigger_detect (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Configuration
    input wire enable,
    input wire level_select,
    input wire polarity,
    // Trigger pin and result
    input wire trigger_pin,
    output reg trigger_hit_q
);

reg sync_first_q; // First synchroniser stage, read only by the second
reg sync_second_q; // Second synchroniser stage
reg sample_prev_q; // Previous synchronised sample for edge detection

// Two-flop synchroniser and previous-sample register
always @(posedge aclk) begin
    if (!aresetn) begin
        sync_first_q <= 1'b0;
        sync_second_q <= 1'b0;
        sample_prev_q <= 1'b0;
    end else begin
        sync_first_q <= trigger_pin;
        sync_second_q <= sync_first_q;
        sample_prev_q <= sync_second_q;
    end
end

// Sensitivity decode: falling, rising, low level, high level
always @(posedge aclk) begin
    if (!aresetn) begin
        trigger_hit_q <= 1'b0;
    end else if (!enable) begin
        trigger_hit_q <= 1'b0;
    end else begin
        case ({level_select, polarity})
            2'h0: trigger_hit_q <= sample_prev_q & ~sync_second_q;
            2'h1: trigger_hit_q <= ~sample_prev_q & sync_second_q;
            2'h2: trigger_hit_q <= ~sync_second_q;
            2'h3: trigger_hit_q <= sync_second_q;
            default: trigger_hit_q <= 1'b0;
        endcase
    end
end

endmodule

// [rtl/power_sequencer.v]
// Purpose: Track converter power and the recovery period after power-up
// Assumes: Powered state is requested as a level
// Notes: Any drop of the request restarts the recovery count
`timescale 1ns/10ps
module power_sequencer #(
    parameter RECOVERY_CYCLES = 200
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Request and status
    input wire power_request,
    output reg analog_on_q,
    output reg ready_q
);

reg [15:0] count_q; // Cycles left in the recovery period

// Recovery counter, restarted at every power-up
always @(posedge aclk) begin
    if (!aresetn) begin
        analog_on_q <= 1'b0;
        ready_q <= 1'b0;
        count_q <= 16'h0000;
    end else if (!power_request) begin
        analog_on_q <= 1'b0;
        ready_q <= 1'b0;
        count_q <= RECOVERY_CYCLES[15:0];
    end else begin
        analog_on_q <= 1'b1;
        if (count_q != 16'h0000) begin
            count_q <= count_q - 16'h0001;
        end
        ready_q <= (count_q == 16'h0000);
    end
end

endmodule

// [verif/convctl_properties.sv]
// Purpose: Port-level checks on the converter control block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into every instance of the block
`timescale 1ns/10ps
module convctl_properties #(
    parameter RECOVERY_CYCLES = 200
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Bus answers
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Engine steering and status
    input wire wait_mode,
    input wire sequence_abort_q,
    input wire conversion_halt_q,
    input wire resume_discard_q,
    input wire analog_power_q,
    input wire converter_ready_q,
    input wire trigger_start_q,
    input wire trigger_mode_q
);
    reg [15:0] on_q; // Cycles of unbroken analog power, saturating
    // Counts powered cycles so the recovery wait can be judged
    always @(posedge aclk) begin
        if (!aresetn || !analog_power_q) begin
            on_q <= 16'h0000;
        end else if (on_q != 16'hFFFF) begin
            on_q <= on_q + 16'h0001;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_answer;
        $rose(s_axi_bvalid);
    endsequence
    sequence s_one_pulse;
        !wait_mode ##1 !resume_discard_q;
    endsequence
    property p_abort;
        sequence_abort_q |-> s_wr_answer;
    endproperty
    a_abort: assert property (p_abort) else $error("abort without a write");
    property p_recover;
        $rose(converter_ready_q) |-> on_q >= RECOVERY_CYCLES;
    endproperty
    a_recover: assert property (p_recover) else $error("ready too early");
    property p_off;
        !analog_power_q [*3] |-> !converter_ready_q;
    endproperty
    a_off: assert property (p_off) else $error("ready while off");
    property p_halt;
        conversion_halt_q [*3] |-> !analog_power_q;
    endproperty
    a_halt: assert property (p_halt) else $error("powered while halted");
    property p_trig;
        !trigger_mode_q [*4] |-> !trigger_start_q;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger while disabled");
    property p_resume;
        resume_discard_q |-> s_one_pulse;
    endproperty
    a_resume: assert property (p_resume) else $error("bad discard pulse");
    property p_bdrop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer held");
    property p_rdrop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer held");
endmodule
bind converter_control convctl_properties #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_props (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
    .wait_mode, .sequence_abort_q, .conversion_halt_q, .resume_discard_q,
    .analog_power_q, .converter_ready_q, .trigger_start_q, .trigger_mode_q
);

// [verif/far_side_model.sv]
// Purpose: Conversion engine stand-in that answers the control block
// Assumes: One conversion per start command, three cycles long
// Notes: Sequence flag stays until the next start
`timescale 1ns/10ps
module far_side_model (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Commands from the bench
    input wire start_conv,
    input wire [2:0] channel,
    // Steering from the block
    input wire halt,
    input wire abort,
    // Results toward the block
    output reg seq_flag,
    output reg [7:0] done
);
    reg [1:0] left_q; // Cycles left in the running conversion
    // Runs one conversion; abort or halt stops it
    always @(posedge aclk) begin
        done <= 8'h00;
        if (!aresetn) begin
            left_q <= 2'h0;
            seq_flag <= 1'b0;
        end else if (abort || halt) begin
            left_q <= 2'h0;
        end else if (start_conv) begin
            left_q <= 2'h3;
            seq_flag <= 1'b0;
        end else if (left_q == 2'h1) begin
            left_q <= 2'h0;
            done[channel] <= 1'b1;
            seq_flag <= 1'b1;
        end else if (left_q != 2'h0) begin
            left_q <= left_q - 2'h1;
        end
    end
endmodule

// [verif/adc_power_trigger_irq_control_tb_top.sv]
// Purpose: Self-checking bench for the converter control block
// Assumes: Recovery shortened to 5 cycles
// Notes: Outputs sampled at falling edges, inputs driven after rising edges
`timescale 1ns/10ps
module adc_power_trigger_irq_control_tb_top;
    localparam REC = 5; // Shortened recovery count
    localparam [7:0] CTL = 8'h08; // Control register address
    // Clock, reset and bus
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] awa = 8'h00;
    reg [7:0] ara = 8'h00;
    reg [31:0] wd = 32'h0;
    reg awv = 1'b0;
    reg wv = 1'b0;
    reg bq = 1'b0;
    reg arv = 1'b0;
    reg rq = 1'b0;
    wire awr, wrdy, bv, arr, rv;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    // Engine side, trigger and status
    reg wmode = 1'b0;
    reg pin = 1'b0;
    reg go = 1'b0;
    reg [2:0] ch = 3'h0;
    wire seq_f, abort, halt, disc, pwr, rdy, tst, tmode, irq;
    wire [7:0] done, ccf, clrd;
    // Bookkeeping
    integer miscompares = 0;
    integer n_compared = 0;
    integer n_abort = 0;
    integer n_ctlw = 0;
    integer n_trig = 0;
    integer n_disc = 0;
    integer n_clr = 0; // Cycles with a flag clear pulse
    integer cyc = 0;
    integer k;
    reg [31:0] d;
    reg [1:0] r;

    always #50 aclk = ~aclk;

    converter_control #(.RECOVERY_CYCLES(REC)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rq), .sequence_complete_flag(seq_f),
        .conversion_done(done), .wait_mode(wmode), .sequence_abort_q(abort),
        .conversion_halt_q(halt), .resume_discard_q(disc), .analog_power_q(pwr),
        .converter_ready_q(rdy), .conversion_complete_flag_q(ccf), .clear_done_q(clrd),
        .trigger_pin(pin), .trigger_start_q(tst), .trigger_mode_q(tmode), .irq_q(irq));
    far_side_model u_far (.aclk, .aresetn, .start_conv(go), .channel(ch), .halt(halt),
        .abort(abort), .seq_flag(seq_f), .done(done));

    // Counts pulses and cuts a hang short
    always @(negedge aclk) begin
        cyc = cyc + 1;
        if (abort === 1'b1) n_abort = n_abort + 1;
        if (tst === 1'b1) n_trig = n_trig + 1;
        if (disc === 1'b1) n_disc = n_disc + 1;
        if ((|clrd) === 1'b1) n_clr = n_clr + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end

    task chk(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task conclude;
        begin
            $display("compared %0d mismatched %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // Waits n rising edges, then settles to the falling edge
    task tick(input integer n);
        begin
            repeat (n) @(posedge aclk);
            @(negedge aclk);
        end
    endtask
    // One write; address and data released each when taken
    task put(input [7:0] a, input [31:0] v);
        reg [1:0] p;
        reg [1:0] h;
        begin
            p = 2'b11;
            @(posedge aclk);
            awa <= a;
            wd <= v;
            awv <= 1'b1;
            wv <= 1'b1;
            bq <= 1'b1;
            while (p != 2'b00) begin
                @(negedge aclk);
                h = {awr === 1'b1, wrdy === 1'b1} & p;
                @(posedge aclk);
                if (h[1]) awv <= 1'b0;
                if (h[0]) wv <= 1'b0;
                p = p & ~h;
            end
            do @(negedge aclk); while (bv !== 1'b1);
            r = br;
            @(posedge aclk);
            bq <= 1'b0;
            if (a == CTL) n_ctlw = n_ctlw + 1;
            chk(r, 2'h0);
        end
    endtask
    // One read; data and response kept in d and r
    task get(input [7:0] a);
        begin
            @(posedge aclk);
            ara <= a;
            arv <= 1'b1;
            rq <= 1'b1;
            do @(negedge aclk); while (arr !== 1'b1);
            @(posedge aclk);
            arv <= 1'b0;
            do @(negedge aclk); while (rv !== 1'b1);
            d = rdat;
            r = rr;
            @(posedge aclk);
            rq <= 1'b0;
        end
    endtask
    task getx(input [7:0] a, input [31:0] e);
        begin
            get(a);
            chk(d, e);
            chk(r, 2'h0);
        end
    endtask
    // Starts one conversion on channel c and lets it finish
    task conv(input [2:0] c);
        begin
            @(posedge aclk);
            ch <= c;
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            tick(6);
        end
    endtask

    initial begin
        tick(11);
        @(posedge aclk) aresetn <= 1'b1;
        getx(CTL, 32'h0);
        get(8'h10);
        chk(r, 2'h2);
        put(CTL, 32'hFF);
        getx(CTL, 32'hFE);
        chk(tmode, 1'b1);
        put(CTL, 32'h00);
        tick(4);
        chk({pwr, rdy, tmode}, 3'b000);
        put(CTL, 32'h80);
        tick(2);
        chk({pwr, rdy}, 2'b10);
        tick(REC + 6);
        chk(rdy, 1'b1);
        // Sequence-complete flag, gated view and interrupt
        conv(3'h3);
        getx(CTL, 32'h80);
        chk(irq, 1'b0);
        put(CTL, 32'h82);
        getx(CTL, 32'h83);
        chk(irq, 1'b1);
        put(CTL, 32'h80);
        tick(2);
        chk(irq, 1'b0);
        get(8'h20);
        chk(d[0], 1'b1);
        put(8'h24, 32'h1);
        tick(2);
        chk(irq, 1'b1);
        put(8'h20, 32'h7);
        tick(2);
        chk(irq, 1'b0);
        getx(8'h20, 32'h0);
        // Normal flag clearing needs the status read first
        chk(ccf[3], 1'b1);
        get(8'h4C);
        tick(2);
        chk(ccf[3], 1'b1);
        get(8'h28);
        chk(d[3], 1'b1);
        get(8'h4C);
        tick(2);
        chk(ccf[3], 1'b0);
        // Fast clearing on a plain result write
        put(CTL, 32'hC0);
        conv(3'h5);
        chk(ccf[5], 1'b1);
        put(8'h54, 32'h0);
        tick(2);
        chk(ccf[5], 1'b0);
        // All four trigger sensitivities
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge aclk) pin <= ~k[0];
            put(CTL, 32'h84 | (k << 3));
            tick(6);
            n_trig = 0;
            @(posedge aclk) pin <= k[0];
            tick(8);
            chk(k[1] ? tst : (n_trig == 1), 1'b1);
        end
        put(CTL, 32'h98);
        tick(4);
        n_trig = 0;
        tick(8);
        chk(n_trig, 0);
        chk(tmode, 1'b0);
        // Wait with and without power-down
        put(CTL, 32'hA0);
        @(posedge aclk) wmode <= 1'b1;
        tick(4);
        chk({halt, pwr}, 2'b10);
        getx(CTL, 32'hA0);
        @(posedge aclk) wmode <= 1'b0;
        tick(8);
        chk(n_disc, 1);
        put(CTL, 32'h80);
        @(posedge aclk) wmode <= 1'b1;
        tick(4);
        chk({halt, pwr}, 2'b01);
        @(posedge aclk) wmode <= 1'b0;
        tick(2);
        chk(n_abort, n_ctlw);
        chk(n_clr, 2);
        conclude;
    end
endmodule
